// >>> src/display_identity_image_provider_pkg.sv
// shared constants and types of the display-identity provider
// assumes a 100 MHz reference clock and a one-byte-offset image store
`default_nettype none

package display_identity_image_provider_pkg;

	localparam int REF_CLK_MHZ = 100;
	// pause between probes of the far bus when nothing answers
	localparam int REMOTE_RETRY_US = 10;
	localparam int REMOTE_RETRY_CYC = REMOTE_RETRY_US * REF_CLK_MHZ;

	localparam logic [7:0] DDC_ADDR = 8'hA0;
	localparam int IMAGE_BYTES = 256;
	localparam int IMAGE_AW = 8;
	localparam logic [7:0] IMAGE_LAST = 8'hFF;
	localparam logic [7:0] OFFSET_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;

	typedef enum logic [1:0] {
		MODE_LOCAL = 2'b00,
		MODE_HOST = 2'b01,
		MODE_REMOTE = 2'b10,
		MODE_FACTORY = 2'b11
	} mode_t;
	localparam mode_t MODE_RST = MODE_LOCAL;

	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_ADDR = 3'b001,
		D_AACK = 3'b010,
		D_WOFS = 3'b011,
		D_WACK = 3'b100,
		D_RD = 3'b101,
		D_RACK = 3'b110,
		D_RLOAD = 3'b111
	} ddc_state_t;

	typedef enum logic [2:0] {
		S_INIT = 3'b000,
		S_HOSTWAIT = 3'b001,
		S_FUSE = 3'b010,
		S_REM_REQ = 3'b011,
		S_REM_WAIT = 3'b100,
		S_REM_PAUSE = 3'b101,
		S_READY = 3'b110
	} load_state_t;

	typedef enum logic [1:0] {
		L_IDLE = 2'b00,
		L_BUSY = 2'b01,
		L_BACKOFF = 2'b10
	} link_state_t;

endpackage

`default_nettype wire

// >>> src/link_byte_fetcher.sv
// link-clock side: one far-bus byte read per request toggle
// assumes the link agent answers a held request with a done or lost pulse
`default_nettype none

module link_byte_fetcher (
	// link clock and reference-domain reset
	input wire logic i_link_clk,
	input wire logic i_reset,
	// handshake with the reference domain
	input wire logic i_req_tgl,
	input wire logic [display_identity_image_provider_pkg::IMAGE_AW-1:0] i_req_offset,
	output logic o_ack_tgl,
	output logic [7:0] o_rdata,
	output logic o_found,
	// link sideband channel
	output logic o_link_req,
	output logic [7:0] o_link_dev_addr,
	output logic [display_identity_image_provider_pkg::IMAGE_AW-1:0] o_link_offset,
	input wire logic i_link_done,
	input wire logic i_link_nack,
	input wire logic i_link_arb_lost,
	input wire logic [7:0] i_link_rdata
);
	import display_identity_image_provider_pkg::*;

	logic rst_meta_reg, rst_sync_reg;
	logic req_meta_reg, req_sync_reg;
	link_state_t state_reg, state_next;
	logic seen_reg, seen_next;
	logic ack_reg, ack_next;
	logic found_reg, found_next;
	logic req_reg, req_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [IMAGE_AW-1:0] ofs_reg, ofs_next;

	// reset and request toggle both cross from the reference clock
	always_ff @(posedge i_link_clk) begin
		rst_meta_reg <= i_reset;
		rst_sync_reg <= rst_meta_reg;
		req_meta_reg <= i_req_tgl;
		req_sync_reg <= req_meta_reg;
	end

	always_comb begin
		state_next = state_reg;
		seen_next = seen_reg;
		ack_next = ack_reg;
		found_next = found_reg;
		req_next = req_reg;
		rdata_next = rdata_reg;
		ofs_next = ofs_reg;
		unique case (state_reg)
			L_IDLE: begin
				if (req_sync_reg != seen_reg) begin
					seen_next = req_sync_reg;
					// offset has been stable since before the toggle
					ofs_next = i_req_offset;
					req_next = 1'b1;
					state_next = L_BUSY;
				end
			end
			L_BUSY: begin
				if (i_link_arb_lost) begin
					// another master won; drop and bid again
					req_next = 1'b0;
					state_next = L_BACKOFF;
				end else if (i_link_done) begin
					req_next = 1'b0;
					rdata_next = i_link_rdata;
					found_next = !i_link_nack;
					ack_next = !ack_reg;
					state_next = L_IDLE;
				end
			end
			L_BACKOFF: begin
				req_next = 1'b1;
				state_next = L_BUSY;
			end
			default: begin
				req_next = 1'b0;
				state_next = L_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_link_clk) begin
		if (rst_sync_reg) begin
			state_reg <= L_IDLE;
			seen_reg <= 1'b0;
			ack_reg <= 1'b0;
			found_reg <= 1'b0;
			req_reg <= 1'b0;
			rdata_reg <= BYTE_RST;
			ofs_reg <= OFFSET_RST;
		end else begin
			state_reg <= state_next;
			seen_reg <= seen_next;
			ack_reg <= ack_next;
			found_reg <= found_next;
			req_reg <= req_next;
			rdata_reg <= rdata_next;
			ofs_reg <= ofs_next;
		end
	end

	assign o_ack_tgl = ack_reg;
	assign o_rdata = rdata_reg;
	assign o_found = found_reg;
	assign o_link_req = req_reg;
	assign o_link_dev_addr = DDC_ADDR;
	assign o_link_offset = ofs_reg;

	default clocking cb @(posedge i_link_clk); endclocking
	default disable iff (rst_sync_reg);

	sequence s_lost;
		o_link_req && i_link_arb_lost;
	endsequence

	a_req_held: assert property (
		o_link_req && !i_link_done && !i_link_arb_lost |=> o_link_req)
		else $error("link request dropped before an answer");
	a_arb_retry: assert property (
		s_lost |=> !o_link_req ##1 o_link_req)
		else $error("lost arbitration not retried");
	a_ack_flip: assert property (
		state_reg == L_BUSY && i_link_done && !i_link_arb_lost
		|=> o_ack_tgl != $past(o_ack_tgl) && o_found == !$past(i_link_nack))
		else $error("finished read not handed back");

endmodule // link_byte_fetcher

`default_nettype wire

// >>> src/display_identity_image_source_provider.sv
// display-identity provider: image store, loaders, DDC slave, hot-plug
// assumes host and fuse ports run on i_ref_clk; pins and link cross in
//
// Summary of operation
// - four image sources: local, host, remote, factory
// - source chosen by straps or control override
// - image answered on DDC at address 0xA0
// - local EEPROM mode enables the external EEPROM and keeps off DDC
// - 256-byte volatile store must be loaded first
// - host reads back store anytime; a host write is lost in a cycle where a loader writes
// - remote mode probes far bus, copies found image
// - factory mode copies 256 fuse bytes at start
// - factory mode reads answered from internal store
// - link channel bridges I2C with arbitration retry
// - hot-plug held low until device ready
`default_nettype none

module display_identity_image_source_provider #(
	parameter int RETRY_CYC = display_identity_image_provider_pkg::REMOTE_RETRY_CYC
) (
	// clocks and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_link_clk,
	// source selection
	input wire logic [1:0] i_mode_strap,
	input wire logic i_mode_ovr_en,
	input wire logic [1:0] i_mode_ovr,
	// display data channel pins
	input wire logic i_ddc_scl,
	input wire logic i_ddc_sda,
	output logic o_ddc_sda_out,
	output logic o_ddc_sda_oe_n,
	// hot-plug and source power
	input wire logic i_rx_5v,
	output logic o_hpd_out,
	output logic o_hpd_oe_n,
	output logic o_local_eeprom_en,
	// host access to the image store
	input wire logic i_host_wr,
	input wire logic [display_identity_image_provider_pkg::IMAGE_AW-1:0] i_host_addr,
	input wire logic [7:0] i_host_wdata,
	output logic [7:0] o_host_rdata,
	input wire logic i_host_image_valid,
	// factory fuse array
	output logic [display_identity_image_provider_pkg::IMAGE_AW-1:0] o_fuse_addr,
	input wire logic [7:0] i_fuse_data,
	// link sideband channel, on i_link_clk
	output logic o_link_req,
	output logic [7:0] o_link_dev_addr,
	output logic [display_identity_image_provider_pkg::IMAGE_AW-1:0] o_link_offset,
	input wire logic i_link_done,
	input wire logic i_link_nack,
	input wire logic i_link_arb_lost,
	input wire logic [7:0] i_link_rdata,
	// status
	output logic [1:0] o_mode,
	output logic o_image_ready
);
	import display_identity_image_provider_pkg::*;

	localparam int RW = $clog2(RETRY_CYC + 1);
	if (RETRY_CYC < 1) begin : g_bad_retry
		$error("RETRY_CYC must be at least one");
	end

	logic [7:0] mem [0:IMAGE_BYTES-1];

	// pin synchronisers; the third stage is only for edges
	logic scl_meta_reg, scl_sync_reg, scl_last_reg;
	logic sda_meta_reg, sda_sync_reg, sda_last_reg;
	logic [1:0] strap_meta_reg, strap_sync_reg;
	logic rx5v_meta_reg, rx5v_sync_reg;
	logic ack_meta_reg, ack_sync_reg, ack_last_reg, rem_ack_tgl;
	always_ff @(posedge i_ref_clk) begin
		scl_meta_reg <= i_ddc_scl;
		scl_sync_reg <= scl_meta_reg;
		scl_last_reg <= scl_sync_reg;
		sda_meta_reg <= i_ddc_sda;
		sda_sync_reg <= sda_meta_reg;
		sda_last_reg <= sda_sync_reg;
		strap_meta_reg <= i_mode_strap;
		strap_sync_reg <= strap_meta_reg;
		rx5v_meta_reg <= i_rx_5v;
		rx5v_sync_reg <= rx5v_meta_reg;
		ack_meta_reg <= rem_ack_tgl;
		ack_sync_reg <= ack_meta_reg;
		ack_last_reg <= ack_sync_reg;
	end

	logic scl_rise, scl_fall, bus_start, bus_stop, ack_edge;
	assign scl_rise = scl_sync_reg && !scl_last_reg;
	assign scl_fall = !scl_sync_reg && scl_last_reg;
	assign bus_start = scl_sync_reg && scl_last_reg && sda_last_reg &&
		!sda_sync_reg;
	assign bus_stop = scl_sync_reg && scl_last_reg && !sda_last_reg &&
		sda_sync_reg;
	assign ack_edge = ack_sync_reg != ack_last_reg;

	// loader group
	load_state_t ld_state_reg, ld_state_next;
	mode_t mode_reg, mode_next, mode_sel;
	logic [1:0] strap_reg, strap_next;
	logic strap_done_reg, strap_done_next;
	logic [IMAGE_AW-1:0] fuse_addr_reg, fuse_addr_next;
	logic fuse_rd_reg, fuse_rd_next;
	logic [IMAGE_AW-1:0] rem_ofs_reg, rem_ofs_next;
	logic rem_tgl_reg, rem_tgl_next;
	logic [RW-1:0] pause_reg, pause_next;
	logic ready_reg, ready_next;
	logic hpd_oe_n_reg, hpd_oe_n_next;
	logic eeprom_en_reg, eeprom_en_next;
	logic [7:0] host_rdata_reg, host_rdata_next;
	logic rem_found, rem_wr;
	logic [7:0] rem_rdata;

	always_comb begin
		strap_next = strap_reg;
		strap_done_next = 1'b1;
		if (!strap_done_reg) begin
			strap_next = strap_sync_reg;
		end
		// a control override beats the straps
		mode_sel = i_mode_ovr_en ? mode_t'(i_mode_ovr) : mode_t'(strap_next);
		mode_next = mode_sel;
		ld_state_next = ld_state_reg;
		fuse_addr_next = fuse_addr_reg;
		fuse_rd_next = 1'b0;
		rem_ofs_next = rem_ofs_reg;
		rem_tgl_next = rem_tgl_reg;
		pause_next = pause_reg;
		rem_wr = 1'b0;
		unique case (ld_state_reg)
			S_INIT: begin
				unique case (mode_sel)
					MODE_LOCAL: ld_state_next = S_READY;
					MODE_HOST: ld_state_next = S_HOSTWAIT;
					MODE_REMOTE: begin
						rem_ofs_next = OFFSET_RST;
						ld_state_next = S_REM_REQ;
					end
					MODE_FACTORY: begin
						fuse_addr_next = OFFSET_RST;
						ld_state_next = S_FUSE;
					end
				endcase
			end
			S_HOSTWAIT: begin
				if (i_host_image_valid) begin
					ld_state_next = S_READY;
				end
			end
			S_FUSE: begin
				// fuse data is taken in the same cycle as its address; writes start one cycle after entry
				fuse_rd_next = 1'b1;
				if (fuse_rd_reg) begin
					fuse_addr_next = fuse_addr_reg + 8'h01;
					if (fuse_addr_reg == IMAGE_LAST) begin
						fuse_rd_next = 1'b0;
						ld_state_next = S_READY;
					end
				end
			end
			S_REM_REQ: begin
				rem_tgl_next = !rem_tgl_reg;
				ld_state_next = S_REM_WAIT;
			end
			S_REM_WAIT: begin
				if (ack_edge && rem_found) begin
					rem_wr = 1'b1;
					rem_ofs_next = rem_ofs_reg + 8'h01;
					ld_state_next = (rem_ofs_reg == IMAGE_LAST) ? S_READY :
						S_REM_REQ;
				end else if (ack_edge) begin
					// no responder: restart from the first byte
					rem_ofs_next = OFFSET_RST;
					pause_next = RW'(RETRY_CYC - 1);
					ld_state_next = S_REM_PAUSE;
				end
			end
			S_REM_PAUSE: begin
				pause_next = pause_reg - RW'(1);
				if (pause_reg == '0) begin
					ld_state_next = S_REM_REQ;
				end
			end
			S_READY: ;
			default: ld_state_next = S_INIT;
		endcase
		// a new source reloads from scratch
		if (mode_sel != mode_reg) begin
			ld_state_next = S_INIT;
			fuse_rd_next = 1'b0;
		end
		ready_next = ld_state_next == S_READY;
		hpd_oe_n_next = ready_next && rx5v_sync_reg;
		eeprom_en_next = mode_reg == MODE_LOCAL;
		host_rdata_next = mem[i_host_addr];
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			ld_state_reg <= S_INIT;
			mode_reg <= MODE_RST;
			strap_reg <= MODE_RST;
			strap_done_reg <= 1'b0;
			fuse_addr_reg <= OFFSET_RST;
			fuse_rd_reg <= 1'b0;
			rem_ofs_reg <= OFFSET_RST;
			rem_tgl_reg <= 1'b0;
			pause_reg <= '0;
			ready_reg <= 1'b0;
			hpd_oe_n_reg <= 1'b0;
			eeprom_en_reg <= 1'b0;
			host_rdata_reg <= BYTE_RST;
		end else begin
			ld_state_reg <= ld_state_next;
			mode_reg <= mode_next;
			strap_reg <= strap_next;
			strap_done_reg <= strap_done_next;
			fuse_addr_reg <= fuse_addr_next;
			fuse_rd_reg <= fuse_rd_next;
			rem_ofs_reg <= rem_ofs_next;
			rem_tgl_reg <= rem_tgl_next;
			pause_reg <= pause_next;
			ready_reg <= ready_next;
			hpd_oe_n_reg <= hpd_oe_n_next;
			eeprom_en_reg <= eeprom_en_next;
			host_rdata_reg <= host_rdata_next;
		end
	end

	// loaders win a clash with a host write, which is then lost
	always_ff @(posedge i_ref_clk) begin
		if (fuse_rd_reg) begin
			mem[fuse_addr_reg] <= i_fuse_data;
		end else if (rem_wr) begin
			mem[rem_ofs_reg] <= rem_rdata;
		end else if (i_host_wr) begin
			mem[i_host_addr] <= i_host_wdata;
		end
	end

	link_byte_fetcher u_fetch (
		.i_link_clk(i_link_clk),
		.i_reset(i_reset),
		.i_req_tgl(rem_tgl_reg),
		.i_req_offset(rem_ofs_reg),
		.o_ack_tgl(rem_ack_tgl),
		.o_rdata(rem_rdata),
		.o_found(rem_found),
		.o_link_req(o_link_req),
		.o_link_dev_addr(o_link_dev_addr),
		.o_link_offset(o_link_offset),
		.i_link_done(i_link_done),
		.i_link_nack(i_link_nack),
		.i_link_arb_lost(i_link_arb_lost),
		.i_link_rdata(i_link_rdata)
	);

	// DDC slave group
	ddc_state_t d_state_reg, d_state_next;
	logic d_phase_reg, d_phase_next, d_rw_reg, d_rw_next;
	logic [2:0] d_cnt_reg, d_cnt_next;
	logic [7:0] d_shift_reg, d_shift_next, byte_in, load_byte;
	logic [IMAGE_AW-1:0] d_ofs_reg, d_ofs_next;
	logic sda_oe_n_reg, sda_oe_n_next, ddc_load, answering;
	assign byte_in = {d_shift_reg[6:0], sda_sync_reg};
	assign load_byte = mem[d_ofs_reg];
	// in local mode the external EEPROM owns the bus and its offsets
	assign answering = mode_reg != MODE_LOCAL;

	always_comb begin
		d_state_next = d_state_reg;
		d_phase_next = d_phase_reg;
		d_rw_next = d_rw_reg;
		d_cnt_next = d_cnt_reg;
		d_shift_next = d_shift_reg;
		d_ofs_next = d_ofs_reg;
		sda_oe_n_next = sda_oe_n_reg;
		ddc_load = 1'b0;
		unique case (d_state_reg)
			D_IDLE: ;
			D_ADDR: begin
				if (scl_rise) begin
					d_shift_next = byte_in;
					d_cnt_next = d_cnt_reg + 3'h1;
					if (d_cnt_reg == 3'h7) begin
						d_phase_next = 1'b0;
						d_rw_next = byte_in[0];
						d_state_next = (byte_in[7:1] == DDC_ADDR[7:1]) ?
							D_AACK : D_IDLE;
					end
				end
			end
			D_AACK, D_WACK: begin
				if (scl_fall && !d_phase_reg) begin
					sda_oe_n_next = 1'b0;
					d_phase_next = 1'b1;
				end else if (scl_fall) begin
					d_cnt_next = 3'h0;
					sda_oe_n_next = 1'b1;
					if (d_state_reg == D_WACK) begin
						d_state_next = D_IDLE;
					end else if (d_rw_reg) begin
						ddc_load = 1'b1;
						d_state_next = D_RD;
					end else begin
						d_state_next = D_WOFS;
					end
				end
			end
			D_WOFS: begin
				if (scl_rise) begin
					d_shift_next = byte_in;
					d_cnt_next = d_cnt_reg + 3'h1;
					if (d_cnt_reg == 3'h7) begin
						d_ofs_next = byte_in;
						d_phase_next = 1'b0;
						d_state_next = D_WACK;
					end
				end
			end
			D_RD: begin
				if (scl_rise) begin
					d_cnt_next = d_cnt_reg + 3'h1;
					if (d_cnt_reg == 3'h7) begin
						d_phase_next = 1'b0;
						d_state_next = D_RACK;
					end
				end else if (scl_fall) begin
					d_shift_next = {d_shift_reg[6:0], 1'b0};
					sda_oe_n_next = d_shift_reg[6];
				end
			end
			D_RACK: begin
				if (scl_fall && !d_phase_reg) begin
					sda_oe_n_next = 1'b1;
					d_phase_next = 1'b1;
				end else if (scl_rise && d_phase_reg) begin
					d_state_next = sda_sync_reg ? D_IDLE : D_RLOAD;
				end
			end
			D_RLOAD: begin
				if (scl_fall) begin
					d_cnt_next = 3'h0;
					ddc_load = 1'b1;
					d_state_next = D_RD;
				end
			end
			default: d_state_next = D_IDLE;
		endcase
		if (ddc_load) begin
			d_shift_next = load_byte;
			sda_oe_n_next = load_byte[7];
			d_ofs_next = d_ofs_reg + 8'h01;
		end
		if (bus_start) begin
			d_cnt_next = 3'h0;
			sda_oe_n_next = 1'b1;
			d_state_next = D_ADDR;
		end
		if (bus_stop || !answering) begin
			sda_oe_n_next = 1'b1;
			d_state_next = D_IDLE;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			d_state_reg <= D_IDLE;
			d_phase_reg <= 1'b0;
			d_rw_reg <= 1'b0;
			d_cnt_reg <= 3'h0;
			d_shift_reg <= BYTE_RST;
			d_ofs_reg <= OFFSET_RST;
			sda_oe_n_reg <= 1'b1;
		end else begin
			d_state_reg <= d_state_next;
			d_phase_reg <= d_phase_next;
			d_rw_reg <= d_rw_next;
			d_cnt_reg <= d_cnt_next;
			d_shift_reg <= d_shift_next;
			d_ofs_reg <= d_ofs_next;
			sda_oe_n_reg <= sda_oe_n_next;
		end
	end

	// open-drain pins only ever pull low
	always_ff @(posedge i_ref_clk) begin
		o_ddc_sda_out <= 1'b0;
		o_hpd_out <= 1'b0;
	end
	assign o_ddc_sda_oe_n = sda_oe_n_reg;
	assign o_hpd_oe_n = hpd_oe_n_reg;
	assign o_local_eeprom_en = eeprom_en_reg;
	assign o_host_rdata = host_rdata_reg;
	assign o_fuse_addr = fuse_addr_reg;
	assign o_mode = mode_reg;
	assign o_image_ready = ready_reg;

	default clocking cr @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	sequence s_fuse_enter;
		ld_state_reg == S_INIT ##1 ld_state_reg == S_FUSE;
	endsequence
	sequence s_host_write;
		i_host_wr && !fuse_rd_reg && !rem_wr ##1
			i_host_addr == $past(i_host_addr);
	endsequence

	a_fuse_image_len: assert property (
		s_fuse_enter |-> ##257 ld_state_reg == S_READY)
		else $error("fuse copy not 256 bytes long");
	a_local_silent: assert property (
		mode_reg == MODE_LOCAL |=> o_ddc_sda_oe_n && o_local_eeprom_en)
		else $error("device drives DDC in local EEPROM mode");
	a_addr_match: assert property (
		d_state_reg == D_ADDR ##1 d_state_reg == D_AACK
		|-> d_shift_reg[7:1] == DDC_ADDR[7:1])
		else $error("acknowledged a foreign DDC address");
	a_offset_step: assert property (
		ddc_load |=> d_ofs_reg == $past(d_ofs_reg) + 8'h01)
		else $error("read offset did not advance");
	a_read_data: assert property (
		ddc_load && !bus_stop |=> o_ddc_sda_oe_n == $past(load_byte[7]))
		else $error("first data bit not from the store");
	a_hpd_low: assert property (
		!o_image_ready |-> !o_hpd_oe_n)
		else $error("hot-plug released before ready");
	a_host_gate: assert property (
		ld_state_reg == S_HOSTWAIT && !i_host_image_valid &&
		mode_sel == mode_reg |=> !o_image_ready)
		else $error("host image ready without a load");
	a_host_readback: assert property (
		s_host_write |=> o_host_rdata == $past(i_host_wdata, 2))
		else $error("host write not read back");
	a_remote_step: assert property (
		ld_state_reg == S_REM_WAIT && ack_edge && rem_found &&
		mode_sel == mode_reg
		|=> rem_ofs_reg == $past(rem_ofs_reg) + 8'h01)
		else $error("remote byte not stored");
	a_remote_retry: assert property (
		ld_state_reg == S_REM_WAIT && ack_edge && !rem_found &&
		mode_sel == mode_reg |=> ld_state_reg == S_REM_PAUSE ##1
		ld_state_reg != S_READY)
		else $error("missing responder not retried");

endmodule // display_identity_image_source_provider

`default_nettype wire

// >>> sim/ddc_source_model.sv
// video source model: a DDC master that reads the identity image
// assumes an open-drain SDA wire resolved by the bench, SCL from here
`default_nettype none

module ddc_source_model (
	// clock
	input wire logic i_ref_clk,
	// bus lines
	input wire logic i_sda_line,
	output logic o_scl,
	output logic o_sda
);
	timeunit 1ns;
	timeprecision 1ns;

	// quarter bit; the slave needs about 3 clocks to see each edge
	localparam int QTR = 10;

	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	task automatic wait_q();
		repeat (QTR) @(posedge i_ref_clk);
	endtask

	task automatic bit_out(input logic b);
		o_sda <= b;
		wait_q();
		o_scl <= 1'b1;
		wait_q();
		wait_q();
		o_scl <= 1'b0;
		wait_q();
	endtask

	task automatic bit_in(output logic b);
		o_sda <= 1'b1;
		wait_q();
		o_scl <= 1'b1;
		wait_q();
		b = i_sda_line;
		wait_q();
		o_scl <= 1'b0;
		wait_q();
	endtask

	// also serves as repeated start, entered with scl low
	task automatic start();
		o_sda <= 1'b1;
		wait_q();
		o_scl <= 1'b1;
		wait_q();
		o_sda <= 1'b0;
		wait_q();
		o_scl <= 1'b0;
		wait_q();
	endtask

	task automatic stop();
		o_sda <= 1'b0;
		wait_q();
		o_scl <= 1'b1;
		wait_q();
		o_sda <= 1'b1;
		wait_q();
	endtask

	// msb first; ack low means taken
	task automatic put_byte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_in(ack);
	endtask

	task automatic get_byte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_in(d[i]);
		end
		bit_out(last);
	endtask

endmodule // ddc_source_model

`default_nettype wire

// >>> sim/display_identity_image_source_provider_tb.sv
// bench for the display-identity provider, one task per scenario
// assumes the DDC source model; link agent and fuse array live here
`default_nettype none

module display_identity_image_source_provider_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import display_identity_image_provider_pkg::*;

	logic ref_clk, link_clk, reset, ovr_en, host_wr, image_valid;
	logic [1:0] ovr, mode;
	logic [7:0] host_addr, host_wdata, host_rdata, fuse_addr, fuse_data;
	logic link_done, link_nack, link_lost, link_req;
	logic [7:0] link_rdata, link_dev_addr, link_offset;
	logic scl, sda_src, sda_out, sda_oe_n, sda_line;
	logic hpd_out, hpd_oe_n, eeprom_en, ready, lost_seen, nack_seen;
	int fail_count, compares, cycles, lcnt;

	// pull-up on sda: low if either party pulls
	assign sda_line = sda_src & (sda_oe_n | sda_out);
	assign fuse_data = {fuse_addr[3:0], fuse_addr[7:4]};

	display_identity_image_source_provider #(.RETRY_CYC(20)) display_identity_image_source_provider_inst (
		.i_ref_clk(ref_clk), .i_reset(reset), .i_link_clk(link_clk),
		.i_mode_strap(2'b00), .i_mode_ovr_en(ovr_en), .i_mode_ovr(ovr),
		.i_ddc_scl(scl), .i_ddc_sda(sda_line), .o_ddc_sda_out(sda_out),
		.o_ddc_sda_oe_n(sda_oe_n), .i_rx_5v(1'b1), .o_hpd_out(hpd_out),
		.o_hpd_oe_n(hpd_oe_n), .o_local_eeprom_en(eeprom_en),
		.i_host_wr(host_wr), .i_host_addr(host_addr),
		.i_host_wdata(host_wdata), .o_host_rdata(host_rdata),
		.i_host_image_valid(image_valid), .o_fuse_addr(fuse_addr),
		.i_fuse_data(fuse_data), .o_link_req(link_req),
		.o_link_dev_addr(link_dev_addr), .o_link_offset(link_offset),
		.i_link_done(link_done), .i_link_nack(link_nack),
		.i_link_arb_lost(link_lost), .i_link_rdata(link_rdata),
		.o_mode(mode), .o_image_ready(ready));

	ddc_source_model ddc_source_model_inst (
		.i_ref_clk(ref_clk), .i_sda_line(sda_line), .o_scl(scl),
		.o_sda(sda_src));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		link_clk = 1'b0;
		#3;
		forever #40 link_clk = ~link_clk;
	end

	// far agent: loses offset 3 once, no responder at offset 0x10 once
	always @(posedge link_clk) begin
		link_done <= 1'b0;
		link_lost <= 1'b0;
		link_nack <= 1'b0;
		link_rdata <= ~link_rdata;
		if (link_req && !link_done && !link_lost) begin
			lcnt <= lcnt + 1;
			if (lcnt == 2) begin
				lcnt <= 0;
				if (link_offset == 8'h03 && !lost_seen) begin
					link_lost <= 1'b1;
					lost_seen <= 1'b1;
				end else begin
					link_done <= 1'b1;
					link_rdata <= link_offset ^ 8'h5A;
					link_nack <= (link_offset == 8'h10) && !nack_seen;
					nack_seen <= nack_seen || (link_offset == 8'h10);
				end
			end
		end else begin
			lcnt <= 0;
		end
	end

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (fail_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic host_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		host_wr <= 1'b1;
		host_addr <= a;
		host_wdata <= d;
	endtask

	task automatic host_idle(input logic [7:0] a);
		@(posedge ref_clk);
		host_wr <= 1'b0;
		host_addr <= a;
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic set_mode(input mode_t m);
		@(posedge ref_clk);
		ovr_en <= 1'b1;
		ovr <= m;
		repeat (4) @(posedge ref_clk);
		check({7'h00, hpd_oe_n}, 8'h00);
		check({7'h00, eeprom_en}, 8'h00);
		check({6'h00, mode}, {6'h00, m});
	endtask

	task automatic wait_ready(input int limit);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < limit) begin
			@(posedge ref_clk);
			n++;
		end
		check({7'h00, ready}, 8'h01);
		check({7'h00, hpd_oe_n}, 8'h01);
		check({7'h00, hpd_out}, 8'h00);
	endtask

	task automatic ddc_refused(input logic [7:0] addr);
		logic a;
		ddc_source_model_inst.start();
		ddc_source_model_inst.put_byte(addr, a);
		ddc_source_model_inst.stop();
		check({7'h00, a}, 8'h01);
	endtask

	// offset write, repeated start, two sequential bytes
	task automatic ddc_read(input logic [7:0] ofs, e0, e1);
		logic a;
		logic [7:0] d;
		ddc_source_model_inst.start();
		ddc_source_model_inst.put_byte(DDC_ADDR, a);
		check({7'h00, a}, 8'h00);
		ddc_source_model_inst.put_byte(ofs, a);
		check({7'h00, a}, 8'h00);
		ddc_source_model_inst.start();
		ddc_source_model_inst.put_byte(DDC_ADDR | 8'h01, a);
		check({7'h00, a}, 8'h00);
		ddc_source_model_inst.get_byte(1'b0, d);
		check(d, e0);
		ddc_source_model_inst.get_byte(1'b1, d);
		check(d, e1);
		ddc_source_model_inst.stop();
	endtask

	task automatic test_local();
		repeat (10) @(posedge ref_clk);
		check({6'h00, mode}, {6'h00, MODE_LOCAL});
		check({7'h00, eeprom_en}, 8'h01);
		ddc_refused(DDC_ADDR);
	endtask

	task automatic test_host();
		set_mode(MODE_HOST);
		for (int i = 0; i < IMAGE_BYTES; i++) begin
			host_write(i[7:0], i[7:0] + 8'h11);
		end
		host_idle(8'h80);
		check(host_rdata, 8'h91);
		check({7'h00, ready}, 8'h00);
		image_valid <= 1'b1;
		wait_ready(20);
		ddc_read(8'hFF, 8'h10, 8'h11);
		host_write(8'h40, 8'hC3);
		host_idle(8'h40);
		check(host_rdata, 8'hC3);
		ddc_read(8'h40, 8'hC3, 8'h52);
		ddc_refused(8'hA4);
	endtask

	task automatic test_factory();
		set_mode(MODE_FACTORY);
		wait_ready(400);
		ddc_read(8'h12, 8'h21, 8'h31);
		ddc_read(8'hFE, 8'hEF, 8'hFF);
	endtask

	task automatic test_remote();
		set_mode(MODE_REMOTE);
		wait_ready(60000);
		check(link_dev_addr, DDC_ADDR);
		check({6'h00, lost_seen, nack_seen}, 8'h03);
		ddc_read(8'h0F, 8'h55, 8'h4A);
		ddc_read(8'h02, 8'h58, 8'h59);
	endtask

	initial begin
		reset = 1'b1;
		ovr_en = 1'b0;
		ovr = 2'b00;
		host_wr = 1'b0;
		host_addr = 8'h00;
		host_wdata = 8'h00;
		image_valid = 1'b0;
		link_done = 1'b0;
		link_nack = 1'b0;
		link_lost = 1'b0;
		link_rdata = 8'h00;
		lost_seen = 1'b0;
		nack_seen = 1'b0;
		lcnt = 0;
		fail_count = 0;
		compares = 0;
		cycles = 0;
		// long enough for the link side to see it through its sync
		repeat (30) @(posedge ref_clk);
		reset <= 1'b0;
		test_local();
		test_host();
		test_factory();
		test_remote();
		report_and_stop();
	end

endmodule // display_identity_image_source_provider_tb

`default_nettype wire
